// ---- rtl/mains_power_fail_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "pfs_map.svh"

module mains_power_fail_sequencer
  import pfs_pkg::*;
#(
  parameter cnt_t HOLD_UP_CYC   = `PFS_HOLD_UP_CYC,
  parameter cnt_t HOLD_DOWN_CYC = `PFS_HOLD_DOWN_CYC,
  parameter cnt_t HALF_CYC      = `PFS_HALF_CYC,
  parameter cnt_t PHASE_CYC     = `PFS_PHASE_CYC,
  parameter cnt_t TIMEOUT_CYC   = `PFS_TIMEOUT_CYC
) (
  input  wire logic      mclk,
  input  wire logic      reset_n,
  input  wire logic      zero_cross_a,
  input  wire logic      zero_cross_b,
  input  wire cnt_t      pulse_timeout,
  input  wire adc_code_t rail_5v_code,
  input  wire adc_code_t rail_p12_code,
  input  wire adc_code_t rail_n12_code,
  output logic           mains_pulse,
  output logic           line_loss_n,
  output logic           shutdown_warn_n,
  output logic           system_hold_n,
  output logic           power_good,
  output logic           line_sync,
  output logic           led_5v,
  output logic           led_p12,
  output logic           led_n12
);

  pwr_state_t state;
  logic       cross_a_prev;
  logic       pulse_prev;
  logic       pulse_event;
  logic       alive;
  logic       fail_now;
  logic       sync_rise;
  logic       sync_locked;
  cnt_t       gap_cnt;
  cnt_t       seq_cnt;
  cnt_t       phase_cnt;
  cnt_t       timeout_lim;

  // Zero selects the built-in timeout
  assign timeout_lim = (pulse_timeout == `PFS_CNT_ZERO) ? TIMEOUT_CYC : pulse_timeout;

  // Pulse flop: clear has priority, as the clear pin of a real flop would
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cross_a_prev <= 1'b0;
      mains_pulse  <= 1'b0;
    end else begin
      cross_a_prev <= zero_cross_a;
      if (zero_cross_b) begin
        mains_pulse <= 1'b0;
      end else if (zero_cross_a && !cross_a_prev) begin
        mains_pulse <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pulse_prev <= 1'b0;
    end else begin
      pulse_prev <= mains_pulse;
    end
  end

  assign pulse_event = mains_pulse && !pulse_prev;

  // Presence watchdog; an event in the timeout cycle keeps the line alive
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gap_cnt <= `PFS_CNT_ZERO;
      alive   <= 1'b0;
    end else if (pulse_event) begin
      gap_cnt <= `PFS_CNT_ZERO;
      alive   <= 1'b1;
    end else if (gap_cnt + `PFS_CNT_ONE >= timeout_lim) begin
      alive   <= 1'b0;
    end else begin
      gap_cnt <= gap_cnt + `PFS_CNT_ONE;
    end
  end

  assign fail_now = !alive;

  // Power sequence
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state   <= PWR_OFF;
      seq_cnt <= `PFS_CNT_ZERO;
    end else begin
      unique case (state)
        PWR_OFF: begin
          seq_cnt <= `PFS_CNT_ZERO;
          if (alive) begin
            state <= PWR_UP_WAIT;
          end
        end
        PWR_UP_WAIT: begin
          if (fail_now) begin
            state <= PWR_OFF;
          end else if (seq_cnt + `PFS_CNT_ONE >= HOLD_UP_CYC) begin
            state <= PWR_ON;
          end else begin
            seq_cnt <= seq_cnt + `PFS_CNT_ONE;
          end
        end
        PWR_ON: begin
          seq_cnt <= `PFS_CNT_ZERO;
          if (fail_now) begin
            state <= PWR_DOWN_WAIT;
          end
        end
        PWR_DOWN_WAIT: begin
          if (alive) begin
            state <= PWR_ON;
          end else if (seq_cnt + `PFS_CNT_ONE >= HOLD_DOWN_CYC) begin
            state <= PWR_OFF;
          end else begin
            seq_cnt <= seq_cnt + `PFS_CNT_ONE;
          end
        end
      endcase
    end
  end

  // Output stage, level for level
  // Registered so decode glitches never reach the backplane
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      line_loss_n     <= 1'b0;
      shutdown_warn_n <= 1'b0;
      system_hold_n   <= 1'b0;
      power_good      <= 1'b0;
    end else begin
      line_loss_n     <= (state == PWR_UP_WAIT) || (state == PWR_ON);
      shutdown_warn_n <= (state == PWR_UP_WAIT) || (state == PWR_ON);
      system_hold_n   <= (state == PWR_ON) || (state == PWR_DOWN_WAIT);
      power_good      <= (state == PWR_ON) || (state == PWR_DOWN_WAIT);
    end
  end

  // Phase wave: each event re-aims the next rising edge at 120 degrees,
  // and the free-running half counter carries it through lost pulses.
  // Held low until the first event, so the first half is never stretched
  always_ff @(posedge mclk) begin
    if (!reset_n || !system_hold_n) begin
      line_sync <= 1'b0;
      phase_cnt <= HALF_CYC;
      sync_rise <= 1'b0;
      sync_locked <= 1'b0;
    end else if (pulse_event) begin
      phase_cnt <= PHASE_CYC;
      sync_rise <= 1'b1;
      sync_locked <= 1'b1;
    end else if (phase_cnt <= `PFS_CNT_ONE) begin
      if (sync_locked) begin
        line_sync <= sync_rise ? 1'b1 : !line_sync;
      end
      sync_rise <= 1'b0;
      phase_cnt <= HALF_CYC;
    end else begin
      phase_cnt <= phase_cnt - `PFS_CNT_ONE;
    end
  end

  // Rail windows
  rail_if rail_5v ();
  rail_if rail_p12 ();
  rail_if rail_n12 ();

  assign rail_5v.code  = rail_5v_code;
  assign rail_p12.code = rail_p12_code;
  assign rail_n12.code = rail_n12_code;
  assign led_5v        = rail_5v.in_range;
  assign led_p12       = rail_p12.in_range;
  assign led_n12       = rail_n12.in_range;

  rail_window #(.LO(`PFS_5V_LO), .HI(`PFS_5V_HI)) win_5v (
    .mclk    (mclk),
    .reset_n (reset_n),
    .rail    (rail_5v)
  );

  rail_window #(.LO(`PFS_12V_LO), .HI(`PFS_12V_HI)) win_p12 (
    .mclk    (mclk),
    .reset_n (reset_n),
    .rail    (rail_p12)
  );

  // Negative rail is inverted by its divider, so it reads as a positive code
  rail_window #(.LO(`PFS_12V_LO), .HI(`PFS_12V_HI)) win_n12 (
    .mclk    (mclk),
    .reset_n (reset_n),
    .rail    (rail_n12)
  );

endmodule  // mains_power_fail_sequencer

`default_nettype wire

// ---- rtl/pfs_map.svh ----
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// Clock rate
`define PFS_CLK_MHZ        50

// Times in microseconds
`define PFS_HOLD_UP_US     225000
`define PFS_HOLD_DOWN_US   525000
`define PFS_HALF_CYCLE_US  8333
`define PFS_PHASE_US       5555
`define PFS_TIMEOUT_US     25000

// Cycle counts derived from the times
`define PFS_HOLD_UP_CYC    (`PFS_HOLD_UP_US * `PFS_CLK_MHZ)
`define PFS_HOLD_DOWN_CYC  (`PFS_HOLD_DOWN_US * `PFS_CLK_MHZ)
`define PFS_HALF_CYC       (`PFS_HALF_CYCLE_US * `PFS_CLK_MHZ)
`define PFS_PHASE_CYC      (`PFS_PHASE_US * `PFS_CLK_MHZ)
`define PFS_TIMEOUT_CYC    (`PFS_TIMEOUT_US * `PFS_CLK_MHZ)

// Converter windows, nominal code 0x200 on every rail
`define PFS_ADC_W          10
`define PFS_5V_LO          10'h1e7
`define PFS_5V_HI          10'h219
`define PFS_12V_LO         10'h1d8
`define PFS_12V_HI         10'h228

`define PFS_CNT_ZERO       32'h0000_0000
`define PFS_CNT_ONE        32'h0000_0001

`endif

// ---- rtl/pfs_pkg.sv ----
`include "pfs_map.svh"

package pfs_pkg;
  typedef enum logic [1:0] {
    PWR_OFF       = 2'b00,
    PWR_UP_WAIT   = 2'b01,
    PWR_ON        = 2'b10,
    PWR_DOWN_WAIT = 2'b11
  } pwr_state_t;

  typedef logic [`PFS_ADC_W-1:0] adc_code_t;
  typedef logic [31:0]           cnt_t;
endpackage

// ---- rtl/rail_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface rail_if;
  import pfs_pkg::*;
  adc_code_t code;
  logic      in_range;
  modport checker_end (input code, output in_range);
  modport owner       (output code, input in_range);
endinterface

`default_nettype wire

// ---- rtl/rail_window.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "pfs_map.svh"

module rail_window
  import pfs_pkg::*;
#(
  parameter adc_code_t LO = `PFS_5V_LO,
  parameter adc_code_t HI = `PFS_5V_HI
) (
  input  wire logic   mclk,
  input  wire logic   reset_n,
  rail_if.checker_end rail
);
  // Indicator dark out of reset until first sample is judged
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rail.in_range <= 1'b0;
    end else begin
      rail.in_range <= (rail.code >= LO) && (rail.code <= HI);
    end
  end
endmodule  // rail_window

`default_nettype wire

// ---- verification/mains_source.sv ----
`timescale 1ns/100ps
`default_nettype none
module mains_source #(
  parameter int PERIOD = 100
) (
  input  wire logic mclk,
  input  wire logic mains_on,
  output logic      zero_cross_a,
  output logic      zero_cross_b
);
  int cnt = 0;
  always @(posedge mclk) cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
  // Clear comes half a line on, so the flop sees set then clear
  assign zero_cross_a = mains_on && cnt == 1;
  assign zero_cross_b = mains_on && cnt >= PERIOD / 2 && cnt < PERIOD / 2 + 4;
endmodule // mains_source
`default_nettype wire

// ---- verification/pfs_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module pfs_assertions
  import pfs_pkg::*;
(
  input wire logic      mclk,
  input wire logic      reset_n,
  input wire adc_code_t rail_5v_code,
  input wire logic      line_loss_n,
  input wire logic      shutdown_warn_n,
  input wire logic      system_hold_n,
  input wire logic      power_good,
  input wire logic      line_sync,
  input wire logic      led_5v
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  reset_idle_a: assert property ($rose(reset_n) |->
    !(line_loss_n | system_hold_n | line_sync)) else $error("not idle");
  warn_pair_a: assert property (shutdown_warn_n == line_loss_n)
    else $error("warn differs");
  good_pair_a: assert property (power_good == system_hold_n)
    else $error("good differs");
  loss_first_a: assert property ($rose(system_hold_n) |-> line_loss_n)
    else $error("hold before loss");
  hold_keeps_a: assert property ($fell(line_loss_n) && system_hold_n
    |=> system_hold_n [*8]) else $error("hold dropped early");
  sync_stop_a: assert property (!system_hold_n |=> !line_sync)
    else $error("wave without hold");
  sync_start_a: assert property ($rose(line_sync) |-> system_hold_n)
    else $error("wave rose early");
  led_window_a: assert property (1'h1 |=> led_5v ==
    ($past(rail_5v_code) >= 10'h1e7 && $past(rail_5v_code) <= 10'h219)) else $error("lamp");
  cover property ($rose(system_hold_n));
  cover property ($fell(system_hold_n));
  cover property ($fell(line_loss_n) && system_hold_n);
endmodule // pfs_assertions
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("Error at %0t: %h vs %h", $time, (a), (e)); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge mclk); #2; n++; end \
  if (n >= 3000) begin num_errors++; report_and_stop(); end end
bind mains_power_fail_sequencer pfs_assertions pfs_assertions_i (.*);
module testbench;
  import pfs_pkg::*;
  logic        mclk = 1'h0, reset_n = 1'h0, mains_on = 1'h0;
  logic        zero_cross_a, zero_cross_b, mains_pulse, line_loss_n, shutdown_warn_n;
  logic        system_hold_n, power_good, line_sync, led_5v, led_p12, led_n12;
  logic [29:0] codes = 30'h0;
  cnt_t        pulse_timeout = 32'h0;
  int          num_errors = 0, total_checks = 0, n = 0, cyc = 0, t0 = 0;
  logic [32:0] rows [5] = '{{10'h1e7, 10'h1d8, 10'h228, 3'h7}, {10'h219, 10'h228, 10'h1d8, 3'h7},
    {10'h1e6, 10'h200, 10'h229, 3'h2}, {10'h21a, 10'h1d7, 10'h200, 3'h1},
    {10'h200, 10'h229, 10'h1d7, 3'h4}};
  mains_source mains_source_i (.*);
  // Short counts keep the run small; a line period spans two half waves
  mains_power_fail_sequencer #(.HOLD_UP_CYC(32'hc8), .HOLD_DOWN_CYC(32'h190),
    .HALF_CYC(32'h32), .PHASE_CYC(32'h14), .TIMEOUT_CYC(32'h96))
  mains_power_fail_sequencer_i (.*, .rail_5v_code(codes[29:20]),
    .rail_p12_code(codes[19:10]), .rail_n12_code(codes[9:0]));
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk) cyc <= cyc + 1;
  initial forever #10 mclk = ~mclk;
  initial begin
    repeat (20) @(posedge mclk);
    #2 reset_n = 1'h1;
    @(posedge mclk);
    #2 `CHK({line_loss_n, system_hold_n, power_good, line_sync}, 4'h0)
    $display("reset done");
    foreach (rows[i]) begin
      codes = rows[i][32:3];
      @(posedge mclk);
      #2 `CHK({led_5v, led_p12, led_n12}, rows[i][2:0])
    end
    $display("rails done");
    mains_on = 1'h1;
    `WAITC(line_loss_n === 1'h1)
    `CHK(system_hold_n, 1'h0)
    `WAITC(system_hold_n === 1'h1)
    `CHK(n > 195 && n < 206, 1'h1)
    `WAITC(line_sync === 1'h1)
    `WAITC(line_sync === 1'h0)
    `CHK(n, 50)
    $display("power up done");
    `WAITC(mains_pulse === 1'h1)
    mains_on = 1'h0;
    t0 = cyc;
    `WAITC(line_sync === 1'h1)
    `WAITC(line_sync === 1'h0)
    `WAITC(line_sync === 1'h1)
    `CHK(n, 50)
    `WAITC(line_loss_n === 1'h0)
    `CHK(cyc - t0 > 148 && cyc - t0 < 158, 1'h1)
    `CHK({shutdown_warn_n, system_hold_n}, 2'h1)
    t0 = cyc;
    `WAITC(system_hold_n === 1'h0)
    `CHK(cyc - t0 > 396 && cyc - t0 < 406, 1'h1)
    @(posedge mclk);
    #2 `CHK(line_sync, 1'h0)
    $display("power down done");
    mains_on = 1'h1;
    `WAITC(system_hold_n === 1'h1)
    mains_on = 1'h0;
    `WAITC(line_loss_n === 1'h0)
    mains_on = 1'h1;
    `WAITC(line_loss_n === 1'h1)
    `CHK(system_hold_n, 1'h1)
    $display("brief outage done");
    reset_n = 1'h0;
    repeat (2) @(posedge mclk);
    #2 `CHK({line_loss_n, system_hold_n, line_sync}, 3'h0)
    pulse_timeout = 32'hc8;
    reset_n = 1'h1;
    @(posedge mclk);
    #2 `CHK({line_loss_n, shutdown_warn_n, system_hold_n, power_good, line_sync}, 5'h0)
    $display("mid-run reset done");
    `WAITC(system_hold_n === 1'h1)
    `WAITC(mains_pulse === 1'h0)
    `WAITC(mains_pulse === 1'h1)
    mains_on = 1'h0;
    t0 = cyc;
    `WAITC(line_loss_n === 1'h0)
    `CHK(cyc - t0 > 198 && cyc - t0 < 208, 1'h1)
    $display("programmed timeout done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
